// >>> design/ttr_feature_ctrl.sv
// temperature threshold and error recovery feature handler with axi4-lite registers
`timescale 1ns/1ps

// Overview of operation
// - sensor select 0..8 (0 composite), 1111b sets all
// - recovery attributes come from dword eleven
// - recovery get returns attributes in result
// - bit 16 one enables namespace error
// - bit 16 zero disables namespace error
// - error enable is zero after reset
// - bits 15:0 count 100 ms units
// - limit only for limited-retry commands
// - zero limit means no timeout
// - type 00b over, 01b under, rest reserved
// - over resets FFFFh, under resets 0h
// - reading at or beyond threshold raises warning
// - threshold get returns selected threshold
module ttr_feature_ctrl #(
   parameter int NUM_SENSORS = 8,
   parameter int NUM_NS = 8,
   parameter int UNIT_CYCLES = ttr_pkg::RETRY_UNIT_CYCLES
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // temperature readings, composite in slot 0
   input wire logic [(NUM_SENSORS+1)*16-1:0] temp_reading,
   // recovery engine handshake
   input wire logic recovery_start,
   input wire logic recovery_limited,
   input wire logic recovery_done,
   output logic recovery_abort,
   // feature outputs
   output logic [NUM_NS-1:0] unwritten_block_error_enable,
   output logic temp_critical,
   output logic irq
);
   import ttr_pkg::*;

   // ======================================================
   // state
   typedef enum logic {REC_IDLE, REC_TIMING} ttr_rec_t;
   typedef struct packed {
      logic aw_have; // write address held
      logic [7:0] aw_addr;
      logic w_have; // write data held
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic aw_rdy;
      logic w_rdy;
      logic ar_rdy;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [31:0] cmd;
      logic [31:0] dw11;
      logic [31:0] namespace_identifier;
      logic [31:0] result;
      logic [1:0] cmd_status;
      logic [NUM_SENSORS:0][15:0] over; // per sensor over threshold
      logic [NUM_SENSORS:0][15:0] under; // per sensor under threshold
      logic [NUM_NS-1:0] ulbe;
      logic [15:0] limit; // retry limit in 100 ms units
      ttr_rec_t rec;
      logic [31:0] tick; // cycles left in current unit
      logic [15:0] units; // units left
      logic abort;
      logic temp_crit;
      logic [2:0] int_stat; // 0 done, 1 temp warning, 2 timeout
      logic [2:0] int_mask;
      logic irq;
   } ttr_state_t;

   ttr_state_t r_reg, r_next;
   logic [NUM_SENSORS:0] hot; // per sensor threshold crossing
   logic exec; // command register written this cycle

   // ======================================================
   // threshold compare, one per sensor
   genvar g;
   generate
      for (g = 0; g <= NUM_SENSORS; g++) begin : g_cmp
         assign hot[g] = (temp_reading[g*16 +: 16] >= r_reg.over[g]) ||
                         (temp_reading[g*16 +: 16] <= r_reg.under[g]);
      end
   endgenerate

   // byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            m[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return m;
   endfunction

   assign exec = r_reg.aw_have && r_reg.w_have && !r_reg.bvalid && r_reg.aw_addr == OFF_CMD;

   // ======================================================
   // next state
   always_comb begin
      logic [3:0] sel;
      logic [1:0] typ;
      logic [15:0] val;
      logic [31:0] nidx;
      logic [31:0] c;
      logic ns_ok;
      logic [2:0] ev;
      sel = '0;
      typ = '0;
      val = '0;
      nidx = '0;
      c = '0;
      ns_ok = 1'b0;
      ev = '0;
      r_next = r_reg;
      r_next.abort = 1'b0;
      // address and data taken independently
      if (s_axi_awvalid && r_reg.aw_rdy) begin
         r_next.aw_have = 1'b1;
         r_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && r_reg.w_rdy) begin
         r_next.w_have = 1'b1;
         r_next.w_data = s_axi_wdata;
         r_next.w_strb = s_axi_wstrb;
      end
      if (r_reg.bvalid && s_axi_bready) begin
         r_next.bvalid = 1'b0;
      end
      // perform write once both halves are held
      if (r_reg.aw_have && r_reg.w_have && !r_reg.bvalid) begin
         r_next.aw_have = 1'b0;
         r_next.w_have = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp = RESP_OKAY;
         if (r_reg.aw_addr == OFF_CMD) begin
            r_next.cmd = merge(r_reg.cmd, r_reg.w_data, r_reg.w_strb);
         end else if (r_reg.aw_addr == OFF_DW11) begin
            r_next.dw11 = merge(r_reg.dw11, r_reg.w_data, r_reg.w_strb);
         end else if (r_reg.aw_addr == OFF_NAMESPACE_IDENTIFIER) begin
            r_next.namespace_identifier = merge(r_reg.namespace_identifier, r_reg.w_data, r_reg.w_strb);
         end else if (r_reg.aw_addr == OFF_INT_MASK) begin
            r_next.int_mask = r_reg.w_data[2:0];
         end else if (r_reg.aw_addr == OFF_RESULT || r_reg.aw_addr == OFF_STATUS ||
                      r_reg.aw_addr == OFF_INT_STAT) begin
            r_next.bresp = RESP_OKAY; // read-only, write ignored
         end else begin
            r_next.bresp = RESP_SLVERR; // unmapped
         end
      end
      // command execution uses the freshly merged command word
      if (exec) begin
         c = r_next.cmd;
         sel = r_reg.dw11[SENSOR_SEL_LSB +: 4];
         typ = r_reg.dw11[TYPE_SEL_LSB +: 2];
         val = r_reg.dw11[15:0];
         nidx = r_reg.namespace_identifier - 32'h1;
         ns_ok = (r_reg.namespace_identifier != 32'h0) && (r_reg.namespace_identifier <= 32'(NUM_NS));
         r_next.cmd_status = ST_OK;
         ev[0] = 1'b1;
         if (c[7:0] == FID_TEMP) begin
            if (typ != TYPE_OVER && typ != TYPE_UNDER) begin
               r_next.cmd_status = ST_INVALID;
            end else if (c[CMD_SET_BIT]) begin
               if (sel == SENSOR_ALL) begin
                  for (int i = 0; i <= NUM_SENSORS; i++) begin
                     if (typ == TYPE_OVER) begin
                        r_next.over[i] = val;
                     end else begin
                        r_next.under[i] = val;
                     end
                  end
               end else if (32'(sel) <= 32'(NUM_SENSORS)) begin
                  if (typ == TYPE_OVER) begin
                     r_next.over[sel] = val;
                  end else begin
                     r_next.under[sel] = val;
                  end
               end else begin
                  r_next.cmd_status = ST_INVALID; // reserved select
               end
            end else if (32'(sel) <= 32'(NUM_SENSORS)) begin
               r_next.result = {16'h0000, (typ == TYPE_OVER) ? r_reg.over[sel] :
                                r_reg.under[sel]};
            end else begin
               r_next.cmd_status = ST_INVALID; // all-sensors or reserved select on get
            end
         end else if (c[7:0] == FID_RECOV) begin
            if (!ns_ok) begin
               r_next.cmd_status = ST_INVALID;
            end else if (c[CMD_SET_BIT]) begin
               r_next.ulbe[nidx] = r_reg.dw11[ULBE_BIT];
               r_next.limit = r_reg.dw11[15:0];
            end else begin
               r_next.result = {15'h0000, r_reg.ulbe[nidx], r_reg.limit};
            end
         end else begin
            r_next.cmd_status = ST_INVALID; // feature not handled here
         end
      end
      // read channel
      if (r_reg.rvalid && s_axi_rready) begin
         r_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && r_reg.ar_rdy) begin
         r_next.rvalid = 1'b1;
         r_next.rresp = RESP_OKAY;
         r_next.rdata = '0;
         if (s_axi_araddr == OFF_CMD) begin
            r_next.rdata = r_reg.cmd;
         end else if (s_axi_araddr == OFF_DW11) begin
            r_next.rdata = r_reg.dw11;
         end else if (s_axi_araddr == OFF_NAMESPACE_IDENTIFIER) begin
            r_next.rdata = r_reg.namespace_identifier;
         end else if (s_axi_araddr == OFF_RESULT) begin
            r_next.rdata = r_reg.result;
         end else if (s_axi_araddr == OFF_STATUS) begin
            r_next.rdata = {28'h0000000, r_reg.rec == REC_TIMING, r_reg.temp_crit,
                            r_reg.cmd_status};
         end else if (s_axi_araddr == OFF_INT_STAT) begin
            r_next.rdata = {29'h00000000, r_reg.int_stat};
            r_next.int_stat = '0; // read clears, new events below still win
         end else if (s_axi_araddr == OFF_INT_MASK) begin
            r_next.rdata = {29'h00000000, r_reg.int_mask};
         end else begin
            r_next.rresp = RESP_SLVERR;
         end
      end
      // recovery timer; only limited-retry commands with a nonzero limit are timed
      case (r_reg.rec)
         REC_IDLE: begin
            if (recovery_start && recovery_limited &&
                r_reg.limit != 16'h0000) begin
               r_next.rec = REC_TIMING;
               r_next.tick = 32'(UNIT_CYCLES - 1);
               r_next.units = r_reg.limit;
            end
         end
         REC_TIMING: begin
            if (recovery_done) begin
               r_next.rec = REC_IDLE;
            end else if (r_reg.tick != 32'h0) begin
               r_next.tick = r_reg.tick - 32'h1;
            end else if (r_reg.units == 16'h0001) begin
               r_next.rec = REC_IDLE;
               r_next.abort = 1'b1;
               ev[2] = 1'b1;
            end else begin
               r_next.units = r_reg.units - 16'h0001;
               r_next.tick = 32'(UNIT_CYCLES - 1);
            end
         end
         default: r_next.rec = REC_IDLE;
      endcase
      // warning level and its rising edge as an event
      r_next.temp_crit = |hot;
      ev[1] = (|hot) && !r_reg.temp_crit;
      r_next.int_stat = r_next.int_stat | ev;
      r_next.irq = |(r_next.int_stat & r_next.int_mask);
      // ready flags kept in flops so the ports are registered
      r_next.aw_rdy = !r_next.aw_have;
      r_next.w_rdy = !r_next.w_have;
      r_next.ar_rdy = !r_next.rvalid;
   end

   // ======================================================
   // register stage; reset values are constants only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r_reg <= '0;
         r_reg.ulbe <= '0;
         for (int i = 0; i <= NUM_SENSORS; i++) begin
            r_reg.over[i] <= OVER_RESET;
            r_reg.under[i] <= UNDER_RESET;
         end
         r_reg.rec <= REC_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   // ======================================================
   // outputs
   assign s_axi_awready = r_reg.aw_rdy;
   assign s_axi_wready = r_reg.w_rdy;
   assign s_axi_bvalid = r_reg.bvalid;
   assign s_axi_bresp = r_reg.bresp;
   assign s_axi_arready = r_reg.ar_rdy;
   assign s_axi_rvalid = r_reg.rvalid;
   assign s_axi_rdata = r_reg.rdata;
   assign s_axi_rresp = r_reg.rresp;
   assign recovery_abort = r_reg.abort;
   assign unwritten_block_error_enable = r_reg.ulbe;
   assign temp_critical = r_reg.temp_crit;
   assign irq = r_reg.irq;

   // ======================================================
   // assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_set_cmd(logic [7:0] fid);
      exec && r_next.cmd[CMD_SET_BIT] && r_next.cmd[7:0] == fid;
   endsequence
   sequence s_rec_start;
      r_reg.rec == REC_IDLE && recovery_start && recovery_limited && r_reg.limit != 16'h0000;
   endsequence

   a_set_one_sensor: assert property (s_set_cmd(FID_TEMP) ##0 r_reg.dw11[21:16] == 6'h01
      |=> r_reg.over[1] == $past(r_reg.dw11[15:0]))
      else $error("sensor one over threshold not stored");
   a_set_all_under: assert property (s_set_cmd(FID_TEMP) ##0 r_reg.dw11[21:16] == 6'h1F
      |=> r_reg.under[NUM_SENSORS] == $past(r_reg.dw11[15:0]) &&
          r_reg.under[0] == $past(r_reg.dw11[15:0]))
      else $error("all-sensor under threshold not stored");
   a_reserved_type: assert property (exec && r_reg.dw11[21] && r_next.cmd[7:0] == FID_TEMP
      |=> r_reg.cmd_status == ST_INVALID && $stable(r_reg.over))
      else $error("reserved threshold type accepted");
   a_ulbe_write: assert property (s_set_cmd(FID_RECOV) ##0 r_reg.namespace_identifier == 32'h1
      |=> r_reg.ulbe[0] == $past(r_reg.dw11[16]) && r_reg.limit == $past(r_reg.dw11[15:0]))
      else $error("unwritten block enable not applied");
   a_recov_get: assert property (exec && !r_next.cmd[CMD_SET_BIT] &&
      r_next.cmd[7:0] == FID_RECOV && r_reg.namespace_identifier == 32'h1
      |=> r_reg.result == {15'h0000, $past(r_reg.ulbe[0]), $past(r_reg.limit)})
      else $error("recovery get result wrong");
   a_zero_limit: assert property (r_reg.rec == REC_IDLE && r_reg.limit == 16'h0000
      |=> r_reg.rec == REC_IDLE && !r_reg.abort)
      else $error("timer started with zero limit");
   a_timer_start: assert property (s_rec_start
      |=> r_reg.rec == REC_TIMING && r_reg.tick == 32'(UNIT_CYCLES - 1))
      else $error("recovery timer did not start");
   a_abort_cause: assert property (r_reg.abort |-> $past(r_reg.rec) == REC_TIMING &&
      $past(r_reg.tick) == 32'h0 && $past(r_reg.units) == 16'h0001 && r_reg.int_stat[2])
      else $error("abort without expiry");
   a_temp_warn: assert property (1'b1 |=> temp_critical == $past(|hot))
      else $error("temperature warning missing");
   a_reset_vals: assert property ($past(!aresetn) |-> r_reg.over[0] == OVER_RESET &&
      r_reg.under[0] == UNDER_RESET && r_reg.ulbe == '0)
      else $error("reset values wrong");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
endmodule

// >>> inc/ttr_pkg.sv
// package: offsets, fields, reset values and timing for the feature handler
package ttr_pkg;
   // ======================================================
   // register byte offsets
   localparam logic [7:0] OFF_CMD = 8'h00; // feature id and set flag, write executes
   localparam logic [7:0] OFF_DW11 = 8'h04; // command dword eleven
   localparam logic [7:0] OFF_NAMESPACE_IDENTIFIER = 8'h08; // namespace identifier
   localparam logic [7:0] OFF_RESULT = 8'h0C; // completion dword 0
   localparam logic [7:0] OFF_STATUS = 8'h10; // command status and live state
   localparam logic [7:0] OFF_INT_STAT = 8'h14; // sticky events, clear on read
   localparam logic [7:0] OFF_INT_MASK = 8'h18; // interrupt mask
   // ======================================================
   // field positions
   localparam int CMD_SET_BIT = 8; // 1 = set, 0 = get
   localparam int SENSOR_SEL_LSB = 16; // sensor select 19:16
   localparam int TYPE_SEL_LSB = 20; // threshold type 21:20
   localparam int ULBE_BIT = 16; // unwritten block error enable
   // ======================================================
   // codes and reset values
   localparam logic [7:0] FID_TEMP = 8'h04;
   localparam logic [7:0] FID_RECOV = 8'h05;
   localparam logic [3:0] SENSOR_ALL = 4'hF;
   localparam logic [1:0] TYPE_OVER = 2'h0;
   localparam logic [1:0] TYPE_UNDER = 2'h1;
   localparam logic [15:0] OVER_RESET = 16'hFFFF;
   localparam logic [15:0] UNDER_RESET = 16'h0000;
   localparam logic [1:0] ST_OK = 2'h0;
   localparam logic [1:0] ST_INVALID = 2'h1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ======================================================
   // timing: one retry unit of 100 ms at 20 MHz
   localparam int CLK_HZ = 20000000;
   localparam int RETRY_UNIT_MS = 100;
   localparam int RETRY_UNIT_CYCLES = CLK_HZ / 1000 * RETRY_UNIT_MS;
endpackage

// >>> tb/ttr_host_model.sv
// host model: axi4-lite master that issues feature commands as register cycles
`timescale 1ns/1ps

// ==========================================
// host side of the register bus
module ttr_host_model (
   // clock
   input wire logic aclk,
   // write address, data and response
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   // read address and data
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   import ttr_pkg::*;
   // nothing offered at time zero
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end
   // one write; dropped payload is inverted so nobody can use stale data
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // each channel released at its own ready edge
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (!ad && s_axi_awready === 1'b1) begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (!wd && s_axi_wready === 1'b1) begin
            wd = 1'b1;
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
      end
      // bready stays up until the response edge
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // one read, rready held until rvalid is seen
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // attributes go in dword eleven and the namespace identifier before the executing write
   task automatic cmd(input logic set, input logic [7:0] fid, input logic [31:0] dw,
                      input logic [31:0] ns);
      logic [1:0] r;
      wr(OFF_DW11, dw, r);
      wr(OFF_NAMESPACE_IDENTIFIER, ns, r);
      wr(OFF_CMD, {23'h0, set, fid}, r);
   endtask
endmodule

// >>> tb/tb.sv
// testbench: feature handler driven over its register bus and recovery link
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end

module tb;
   import ttr_pkg::*;
   // ==========================================
   // clock, reset, counters and wires
   localparam int UNIT = 4; // short retry unit keeps timer runs brief
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;
   integer seed = 32'h9f1e56a9;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [143:0] temp_reading = '0;
   logic recovery_start = 1'b0;
   logic recovery_limited = 1'b0;
   logic recovery_done = 1'b0;
   logic recovery_abort, temp_critical, irq;
   logic [7:0] unwritten_block_error_enable;
   // mirror of what the handler should hold
   logic [15:0] thr_m [0:8][0:1];
   logic [7:0] ns_en_m = 8'h00;
   logic [15:0] lim_m = 16'h0000;
   always #25 aclk = ~aclk;
   // ==========================================
   // instances
   ttr_feature_ctrl #(.UNIT_CYCLES(UNIT)) ttr_feature_ctrl_inst (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .temp_reading, .recovery_start, .recovery_limited,
      .recovery_done, .recovery_abort, .unwritten_block_error_enable, .temp_critical, .irq);
   ttr_host_model ttr_host_model_inst (
      .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   // ==========================================
   // expectation helpers
   function automatic logic [31:0] thr_dw(logic [3:0] s, logic [1:0] t, logic [15:0] v);
      return {10'h000, t, s, v};
   endfunction
   function automatic logic [31:0] rec_dw(logic e, logic [15:0] l);
      return {15'h0, e, l};
   endfunction
   // one command, then completion dword and status
   task automatic feat(input logic set, input logic [7:0] fid, input logic [31:0] dw,
                       input logic [31:0] ns, output logic [31:0] res, output logic [31:0] st);
      logic [1:0] r;
      ttr_host_model_inst.cmd(set, fid, dw, ns);
      ttr_host_model_inst.rd(OFF_RESULT, res, r);
      ttr_host_model_inst.rd(OFF_STATUS, st, r);
   endtask
   // store a threshold and mirror it; select 1111b reaches every slot
   task automatic put_thr(input logic [3:0] s, input logic [1:0] t, input logic [15:0] v);
      logic [31:0] res;
      logic [31:0] st;
      feat(1'b1, FID_TEMP, thr_dw(s, t, v), 32'h0, res, st);
      `CHK("set status", ST_OK, st[1:0])
      for (int i = 0; i <= 8; i++) begin
         if (s == SENSOR_ALL || s == i) begin
            thr_m[i][t] = v;
         end
      end
   endtask
   task automatic chk_thr(input logic [3:0] s, input logic [1:0] t);
      logic [31:0] res;
      logic [31:0] st;
      feat(1'b0, FID_TEMP, thr_dw(s, t, 16'h0000), 32'h0, res, st);
      `CHK("threshold", {16'h0000, thr_m[s][t]}, res)
   endtask
   // a malformed command must be refused and store nothing
   task automatic bad(input logic set, input logic [7:0] fid, input logic [31:0] dw,
                      input logic [31:0] ns);
      logic [31:0] res;
      logic [31:0] st;
      feat(set, fid, dw, ns, res, st);
      `CHK("refused status", ST_INVALID, st[1:0])
   endtask
   // one recovery start; count edges after the taking edge until abort
   task automatic rec_try(input logic ltd, input int done_at, input int exp_k);
      int k;
      recovery_start <= 1'b1;
      recovery_limited <= ltd;
      @(posedge aclk);
      recovery_start <= 1'b0;
      k = 0;
      while (k < 30 && recovery_abort !== 1'b1) begin
         @(posedge aclk);
         k++;
         recovery_done <= (k == done_at);
      end
      `CHK("abort edge", exp_k, k)
   endtask
   task automatic wrap_up;
      if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // hang guard, far beyond the few thousand cycles the run needs
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         wrap_up();
      end
   end
   // ==========================================
   // main sequence
   initial begin
      logic [31:0] res;
      logic [31:0] st;
      logic [1:0] r;
      logic [3:0] s;
      logic [3:0] ns;
      logic en;
      int k;
      for (int i = 0; i <= 8; i++) begin
         thr_m[i][0] = OVER_RESET;
         thr_m[i][1] = UNDER_RESET;
      end
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      `CHK("enables after reset", 8'h00, unwritten_block_error_enable)
      for (int i = 0; i <= 8; i++) begin
         chk_thr(i[3:0], TYPE_OVER);
         chk_thr(i[3:0], TYPE_UNDER);
      end
      feat(1'b0, FID_RECOV, 32'h0, 32'h1, res, st);
      `CHK("recovery after reset", 32'h0, res)
      // random sensor and type, the other type must stay put
      repeat (12) begin
         s = 4'h1 + 4'($random(seed) & 7);
         k = $random(seed) & 1;
         put_thr(s, k[1:0], 16'($random(seed)));
         chk_thr(s, k[1:0]);
         chk_thr(s, {1'b0, ~k[0]});
      end
      put_thr(4'h1, TYPE_OVER, 16'h0300);
      chk_thr(4'h1, TYPE_OVER);
      put_thr(SENSOR_ALL, TYPE_OVER, 16'h0200);
      put_thr(SENSOR_ALL, TYPE_UNDER, 16'h0010);
      for (int i = 0; i <= 8; i++) begin
         chk_thr(i[3:0], TYPE_OVER);
      end
      // refused fields
      bad(1'b1, FID_TEMP, thr_dw(4'h1, 2'h2, 16'h1234), 32'h0);
      bad(1'b1, FID_TEMP, thr_dw(4'h1, 2'h3, 16'h1234), 32'h0);
      bad(1'b1, FID_TEMP, thr_dw(4'h9, 2'h0, 16'h1234), 32'h0);
      bad(1'b1, FID_TEMP, thr_dw(4'hE, 2'h1, 16'h1234), 32'h0);
      bad(1'b0, FID_TEMP, thr_dw(4'hF, 2'h0, 16'h0000), 32'h0);
      bad(1'b1, FID_RECOV, rec_dw(1'b1, 16'h0009), 32'h9);
      chk_thr(4'h1, TYPE_OVER);
      chk_thr(4'h1, TYPE_UNDER);
      // readings between thresholds, then on each boundary
      for (int i = 0; i <= 8; i++) begin
         temp_reading[i*16 +: 16] <= 16'h0100 + 16'($random(seed) & 8'hFF);
      end
      k = $unsigned($random(seed)) % 9;
      for (int j = 0; j < 4; j++) begin
         if (j > 0) temp_reading[k*16 +: 16] <= (j == 1) ? 16'h0200 : 16'h000F + 16'(j - 1);
         repeat (3) @(posedge aclk);
         `CHK("critical", (j == 1 || j == 2), temp_critical)
         if (j == 0) ttr_host_model_inst.rd(OFF_INT_STAT, res, r);
      end
      ttr_host_model_inst.rd(OFF_INT_STAT, res, r);
      `CHK("warning event", 1'b1, res[1])
      // recovery attributes, namespace 8 enabled then disabled first
      for (int j = 0; j < 8; j++) begin
         ns = (j < 2) ? 4'h8 : 4'h1 + 4'($random(seed) & 7);
         en = (j < 2) ? ~j[0] : 1'($random(seed));
         lim_m = 16'($random(seed));
         ns_en_m[ns - 1] = en;
         feat(1'b1, FID_RECOV, rec_dw(en, lim_m), {28'h0, ns}, res, st);
         `CHK("enables", ns_en_m, unwritten_block_error_enable)
         feat(1'b0, FID_RECOV, 32'h0, {28'h0, ns}, res, st);
         `CHK("recovery get", rec_dw(ns_en_m[ns - 1], lim_m), res)
      end
      // retry timer: expiry, not limited, finished early, zero limit
      feat(1'b1, FID_RECOV, rec_dw(1'b0, 16'h0002), 32'h1, res, st);
      rec_try(1'b1, 0, 2 * UNIT + 1);
      ttr_host_model_inst.rd(OFF_INT_STAT, res, r);
      `CHK("timeout event", 1'b1, res[2])
      rec_try(1'b0, 0, 30);
      rec_try(1'b1, 3, 30);
      feat(1'b1, FID_RECOV, rec_dw(1'b0, 16'h0000), 32'h1, res, st);
      rec_try(1'b1, 0, 30);
      // interrupt: raise, clear by read, then mask
      ttr_host_model_inst.wr(OFF_INT_MASK, 32'h7, r);
      ttr_host_model_inst.rd(OFF_INT_MASK, res, r);
      `CHK("mask", 3'h7, res[2:0])
      ttr_host_model_inst.rd(OFF_INT_STAT, res, r);
      repeat (2) @(posedge aclk);
      `CHK("irq idle", 1'b0, irq)
      feat(1'b0, FID_TEMP, thr_dw(4'h1, 2'h0, 16'h0), 32'h0, res, st);
      `CHK("irq raised", 1'b1, irq)
      ttr_host_model_inst.rd(OFF_INT_STAT, res, r);
      `CHK("done event", 1'b1, res[0])
      repeat (2) @(posedge aclk);
      `CHK("irq cleared", 1'b0, irq)
      ttr_host_model_inst.wr(OFF_INT_MASK, 32'h0, r);
      feat(1'b0, FID_TEMP, thr_dw(4'h1, 2'h0, 16'h0), 32'h0, res, st);
      `CHK("irq masked", 1'b0, irq)
      // unmapped address
      ttr_host_model_inst.wr(8'h1C, 32'hFFFFFFFF, r);
      `CHK("unmapped write", RESP_SLVERR, r)
      ttr_host_model_inst.rd(8'h1C, res, r);
      `CHK("unmapped read", RESP_SLVERR, r)
      wrap_up();
   end
endmodule
